/* bench/smoe_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module smoe_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // bus and select pin
  input wire logic       scl,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       groupFreqSelectPin,
  // output enables
  input wire logic [6:0] fixedFastClockEnable,
  input wire logic [8:0] selectableClockEnable,
  input wire logic [2:0] fixedSlowClockEnable,
  input wire logic       platformTimeOutputEnable,
  input wire logic       selectableGroupFreq25
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the host holds each bus clock phase four cycles
  sequence s_bitHold;
    sdaOe [*6];
  endsequence
  a_sda_only_low: assert property (sdaOut == 1'b0)
    else $error("sda driven high");
  a_reset_values: assert property ($rose(rst_n) |->
    fixedFastClockEnable == 7'h7F && selectableClockEnable == 9'h1FF &&
    {fixedSlowClockEnable, platformTimeOutputEnable, selectableGroupFreq25} == 5'h1E)
    else $error("enables wrong after reset");
  a_sda_scl_low: assert property ($changed(sdaOe) |-> !$past(scl) && !$past(scl, 2))
    else $error("sda moved with bus clock high");
  a_bit_holds: assert property ($rose(sdaOe) |-> s_bitHold)
    else $error("sda pull ended early");
  a_fast_on_ack: assert property ($changed(fixedFastClockEnable) |-> $rose(sdaOe))
    else $error("fast enables moved outside a data ack");
  a_sel_on_ack: assert property ($changed(selectableClockEnable) |-> $rose(sdaOe))
    else $error("selectable enables moved outside a data ack");
  a_slow_on_ack: assert property (
    $changed({fixedSlowClockEnable, platformTimeOutputEnable}) |-> $rose(sdaOe))
    else $error("slow enables moved outside a data ack");
  // pin path passes a synchroniser, so its cause lies a few cycles back
  a_freq_cause: assert property ($changed(selectableGroupFreq25) |-> $past(sdaOe) ||
    $past(groupFreqSelectPin, 2) != $past(groupFreqSelectPin, 5))
    else $error("group frequency moved without cause");
endmodule // smoe_checker
bind smoe_top smoe_checker u_smoe_checker (
  .clk                      (clk),
  .rst_n                    (rst_n),
  .scl                      (scl),
  .sdaOut                   (sdaOut),
  .sdaOe                    (sdaOe),
  .groupFreqSelectPin       (groupFreqSelectPin),
  .fixedFastClockEnable     (fixedFastClockEnable),
  .selectableClockEnable    (selectableClockEnable),
  .fixedSlowClockEnable     (fixedSlowClockEnable),
  .platformTimeOutputEnable (platformTimeOutputEnable),
  .selectableGroupFreq25    (selectableGroupFreq25)
);
`default_nettype wire

/* bench/smoe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module smoe_host (
  // clock and bus lines
  input  wire logic clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sdaLow
);
  initial scl = 1'b1;
  initial sdaLow = 1'b0;
  task automatic drv(input int n, input logic c, input logic s);
    repeat (n) @(posedge clk);
    #1 scl = c;
    sdaLow = s;
  endtask
  // clock low four cycles for the device's setup, then high four
  task automatic bitx(input logic b, output logic r);
    drv(1, 1'b0, !b);
    drv(3, 1'b1, !b);
    drv(3, 1'b1, !b);
    r = sda;
    drv(1, 1'b0, !b);
  endtask
  // doubles as repeated start: data released before the clock rises
  task automatic start();
    drv(1, scl, 1'b0);
    drv(3, 1'b1, 1'b0);
    drv(4, 1'b1, 1'b1);
    drv(4, 1'b0, 1'b1);
  endtask
  task automatic stop();
    drv(1, 1'b0, 1'b1);
    drv(3, 1'b1, 1'b1);
    drv(4, 1'b1, 1'b0);
    drv(4, 1'b1, 1'b0);
  endtask
  // ninth bit released to read an ack, or driven low; released high on the last read byte
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(nak, ack);
    ack = !ack;
  endtask
endmodule // smoe_host
`default_nettype wire

/* bench/tb_smoe_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_smoe_top;
  logic                  clk, rst_n, pg, pin, scl, sdaLow, sdaOut, sdaOe, pft, f25, ak;
  logic [6:0]            fast;
  logic [8:0]            sel;
  logic [2:0]            slow;
  logic [7:0]            q;
  smoe_pkg::smoe_strap_t straps;
  int                    fail_count, n_checks;
  wire logic             sda;
  assign sda = !sdaLow && !(sdaOe && !sdaOut);
  smoe_top u_smoe_top (.clk, .rst_n, .scl, .sdaIn(sda), .sdaOut, .sdaOe, .straps,
    .powerGoodInput(pg), .groupFreqSelectPin(pin), .fixedFastClockEnable(fast),
    .selectableClockEnable(sel), .fixedSlowClockEnable(slow),
    .platformTimeOutputEnable(pft), .selectableGroupFreq25(f25));
  smoe_host u_smoe_host (.clk, .sda, .scl, .sdaLow);
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic sb(input logic [7:0] d);
    u_smoe_host.xfer(d, 1'b1, q, ak);
    chk("ack", 9'(ak), 9'h1);
  endtask
  // count byte always says three; k bytes really follow
  task automatic wr(input logic [7:0] n, input int k, input logic [23:0] d);
    u_smoe_host.start();
    sb(8'hD2);
    sb(n);
    sb(8'h03);
    for (int i = 0; i < k; i++) begin
      sb(d[23 - 8 * i -: 8]);
    end
    u_smoe_host.stop();
  endtask
  task automatic rd(input logic [7:0] n, input int k, input logic [23:0] e);
    u_smoe_host.start();
    sb(8'hD2);
    sb(n);
    u_smoe_host.start();
    sb(8'hD3);
    u_smoe_host.xfer(8'hFF, 1'b0, q, ak);
    chk("count", 9'(q), 9'(smoe_pkg::READ_COUNT));
    for (int i = 0; i < k; i++) begin
      u_smoe_host.xfer(8'hFF, 1'(i == k - 1), q, ak);
      chk("read", 9'(q), 9'(e[23 - 8 * i -: 8]));
    end
    u_smoe_host.stop();
  endtask
  task automatic t_power_up();
    chk("fast", 9'(fast), 9'h7F);
    chk("sel", sel, 9'h1FF);
    chk("slow", 9'({slow, pft, f25}), 9'h1E);
    rd(8'h00, 3, 24'hFFFF0F);
    pin = 1'b1;
    #200 pg = 1'b1;
    #200 pin = 1'b0;
    rd(8'h02, 1, 24'h2F0000);
    chk("freq", 9'(f25), 9'h0);
  endtask
  task automatic t_write_all();
    wr(8'h00, 3, 24'h5AA5F0);
    chk("fast", 9'(fast), 9'h5A);
    chk("sel", sel, 9'h0A5);
    chk("slow", 9'({slow, pft, f25}), 9'h01);
    rd(8'h00, 3, 24'h5AA5E0);
  endtask
  task automatic t_short_write();
    wr(8'h02, 1, 24'h8F0000);
    chk("slow", 9'({slow, pft, f25}), 9'h1E);
    rd(8'h02, 1, 24'hAF0000);
    #200 pin = 1'b1;
    #400 chk("freq", 9'(f25), 9'h1);
    // register control with choice 0 must override the high pin
    wr(8'h02, 1, 24'h7F0000);
    chk("slow", 9'({slow, pft, f25}), 9'h1E);
    rd(8'h02, 1, 24'h6F0000);
  endtask
  task automatic t_addresses();
    logic [7:0] tbl [9] = '{8'hD2, 8'hD4, 8'hD6, 8'hB2, 8'hB4, 8'hB6, 8'hBA, 8'hBC, 8'hBE};
    for (int i = 0; i < 9; i++) begin
      straps = {2'(i / 3), 2'(i % 3)};
      #200 u_smoe_host.start();
      sb(tbl[i]);
      u_smoe_host.stop();
      u_smoe_host.start();
      u_smoe_host.xfer(tbl[(i + 1) % 9], 1'b1, q, ak);
      chk("foreign address", 9'(ak), 9'h0);
      u_smoe_host.stop();
    end
    straps = 4'h0;
  endtask
  initial begin
    rst_n = 1'b0;
    pg = 1'b0;
    pin = 1'b0;
    straps = 4'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    #200 t_power_up();
    t_write_all();
    t_short_write();
    t_addresses();
    conclude();
  end
  // the whole run needs about 5000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule // tb_smoe_top
`default_nettype wire

/* verilog/smoe_pkg.sv */
`default_nettype none
package smoe_pkg;
  // tri-level strap coding on each two-bit strap input
  localparam logic [1:0] STRAP_LOW  = 2'h0;
  localparam logic [1:0] STRAP_MID  = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // address bytes with the direction bit cleared; rows by upper strap
  localparam logic [7:0] ADDR_LL = 8'hD2;
  localparam logic [7:0] ADDR_LM = 8'hD4;
  localparam logic [7:0] ADDR_LH = 8'hD6;
  localparam logic [7:0] ADDR_ML = 8'hB2;
  localparam logic [7:0] ADDR_MM = 8'hB4;
  localparam logic [7:0] ADDR_MH = 8'hB6;
  localparam logic [7:0] ADDR_HL = 8'hBA;
  localparam logic [7:0] ADDR_HM = 8'hBC;
  localparam logic [7:0] ADDR_HH = 8'hBE;

  // register indices
  localparam logic [7:0] IDX_FAST = 8'h00;
  localparam logic [7:0] IDX_SEL  = 8'h01;
  localparam logic [7:0] IDX_SLOW = 8'h02;

  // reset values
  localparam logic [7:0] FAST_RST = 8'hFF;
  localparam logic [7:0] SEL_RST  = 8'hFF;
  localparam logic [7:0] SLOW_RST = 8'h0F;

  // index 2 field positions and writable mask
  localparam int         FREQ_CHOICE_BIT = 7;
  localparam int         FREQ_SOURCE_BIT = 6;
  localparam int         FREQ_RB_BIT     = 5;
  localparam logic [7:0] SLOW_WR_MASK    = 8'hCF;

  // output enable field positions inside the registers
  localparam int         FAST_EN_MSB     = 6;
  localparam int         SEL8_EN_BIT     = 7;
  localparam int         SLOW_EN_MSB     = 2;
  localparam int         PFT_EN_BIT      = 3;

  // byte count returned first in a block read: registers in this block
  localparam logic [7:0] READ_COUNT = 8'h03;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;

  // receive phases
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_CMD  = 2'h1;
  localparam logic [1:0] PH_CNT  = 2'h2;
  localparam logic [1:0] PH_DATA = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RX    = 5'h02,
    ST_RXACK = 5'h04,
    ST_TX    = 5'h08,
    ST_TXACK = 5'h10
  } smoe_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } smoe_line_t;

  typedef struct packed {
    logic [1:0] upper;
    logic [1:0] lower;
  } smoe_strap_t;
endpackage
`default_nettype wire

/* verilog/smoe_top.sv */
`timescale 1ns/1ps
`default_nettype none
module smoe_top (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // bus pins
  input  wire logic              scl,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  // straps and sideband pins
  input  wire smoe_pkg::smoe_strap_t straps,
  input  wire logic              powerGoodInput,
  input  wire logic              groupFreqSelectPin,
  // output enables
  output logic [6:0]             fixedFastClockEnable,
  output logic [8:0]             selectableClockEnable,
  output logic [2:0]             fixedSlowClockEnable,
  output logic                   platformTimeOutputEnable,
  output logic                   selectableGroupFreq25
);
  smoe_pkg::smoe_line_t  lineS1_r, lineS2_r, linePrev_r;
  smoe_pkg::smoe_strap_t strapS1_r, strapS2_r;
  logic pgS1_r, pgS2_r, pgPrev_r, pinS1_r, pinS2_r;
  logic sdaLow_r;

  smoe_pkg::smoe_state_t state_r, state_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] index_r, index_nxt;
  logic       isRead_r, isRead_nxt;
  logic       oe_r, oe_nxt;
  logic       acked_r, acked_nxt;
  logic [7:0] regFast_r, regFast_nxt;
  logic [7:0] regSel_r, regSel_nxt;
  logic [7:0] regSlow_r, regSlow_nxt;
  logic       latchedFreq_r, latchedFreq_nxt;
  logic       groupFreq_r, groupFreq_nxt;

  logic sclRise, sclFall, startSeen, stopSeen;
  logic [7:0] ownAddr;

  function automatic logic [7:0] strapAddr(input logic [1:0] up, input logic [1:0] lo);
    logic [7:0] a;
    a = smoe_pkg::ADDR_LL;
    if (up == smoe_pkg::STRAP_LOW) begin
      a = (lo == smoe_pkg::STRAP_HIGH) ? smoe_pkg::ADDR_LH :
          (lo == smoe_pkg::STRAP_MID)  ? smoe_pkg::ADDR_LM : smoe_pkg::ADDR_LL;
    end else if (up == smoe_pkg::STRAP_MID) begin
      a = (lo == smoe_pkg::STRAP_HIGH) ? smoe_pkg::ADDR_MH :
          (lo == smoe_pkg::STRAP_MID)  ? smoe_pkg::ADDR_MM : smoe_pkg::ADDR_ML;
    end else begin
      a = (lo == smoe_pkg::STRAP_HIGH) ? smoe_pkg::ADDR_HH :
          (lo == smoe_pkg::STRAP_MID)  ? smoe_pkg::ADDR_HM : smoe_pkg::ADDR_HL;
    end
    return a;
  endfunction

  // read view; in index 2 bit 4 stays zero and bit 5 is the latched pin
  function automatic logic [7:0] readReg(input logic [7:0] idx, input logic [7:0] f,
                                         input logic [7:0] s, input logic [7:0] w,
                                         input logic rb);
    logic [7:0] v;
    v = 8'h00;
    if (idx == smoe_pkg::IDX_FAST) begin
      v = f;
    end else if (idx == smoe_pkg::IDX_SEL) begin
      v = s;
    end else if (idx == smoe_pkg::IDX_SLOW) begin
      v = w & smoe_pkg::SLOW_WR_MASK;
      v[smoe_pkg::FREQ_RB_BIT] = rb;
    end
    return v;
  endfunction

  // straps are not latched after power-up; the address follows them through the synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineS1_r   <= '1;
      lineS2_r   <= '1;
      linePrev_r <= '1;
      strapS1_r  <= '0;
      strapS2_r  <= '0;
      pgS1_r     <= 1'b0;
      pgS2_r     <= 1'b0;
      pgPrev_r   <= 1'b0;
      pinS1_r    <= 1'b0;
      pinS2_r    <= 1'b0;
      sdaLow_r   <= 1'b0;
    end else begin
      lineS1_r   <= '{scl: scl, sda: sdaIn};
      lineS2_r   <= lineS1_r;
      linePrev_r <= lineS2_r;
      strapS1_r  <= straps;
      strapS2_r  <= strapS1_r;
      pgS1_r     <= powerGoodInput;
      pgS2_r     <= pgS1_r;
      pgPrev_r   <= pgS2_r;
      pinS1_r    <= groupFreqSelectPin;
      pinS2_r    <= pinS1_r;
      sdaLow_r   <= 1'b0;
    end
  end

  assign sclRise   = lineS2_r.scl & ~linePrev_r.scl;
  assign sclFall   = ~lineS2_r.scl & linePrev_r.scl;
  assign startSeen = lineS2_r.scl & linePrev_r.scl & linePrev_r.sda & ~lineS2_r.sda;
  assign stopSeen  = lineS2_r.scl & linePrev_r.scl & ~linePrev_r.sda & lineS2_r.sda;
  assign ownAddr   = strapAddr(strapS2_r.upper, strapS2_r.lower);

  always_comb begin
    state_nxt       = state_r;
    phase_nxt       = phase_r;
    bitCnt_nxt      = bitCnt_r;
    shift_nxt       = shift_r;
    index_nxt       = index_r;
    isRead_nxt      = isRead_r;
    oe_nxt          = oe_r;
    acked_nxt       = acked_r;
    regFast_nxt     = regFast_r;
    regSel_nxt      = regSel_r;
    regSlow_nxt     = regSlow_r;
    latchedFreq_nxt = latchedFreq_r;
    if (pgS2_r && !pgPrev_r) begin
      latchedFreq_nxt = pinS2_r;
    end
    // start and stop override any phase; bytes already written stay
    if (startSeen) begin
      state_nxt  = smoe_pkg::ST_RX;
      phase_nxt  = smoe_pkg::PH_ADDR;
      bitCnt_nxt = '0;
      oe_nxt     = 1'b0;
    end else if (stopSeen) begin
      state_nxt = smoe_pkg::ST_IDLE;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        smoe_pkg::ST_RX: begin
          if (sclRise && bitCnt_r != smoe_pkg::BITS_PER_BYTE) begin
            shift_nxt  = {shift_r[6:0], lineS2_r.sda};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end else if (sclFall && bitCnt_r == smoe_pkg::BITS_PER_BYTE) begin
            oe_nxt    = 1'b1;
            state_nxt = smoe_pkg::ST_RXACK;
            if (phase_r == smoe_pkg::PH_ADDR) begin
              if (shift_r[7:1] == ownAddr[7:1]) begin
                isRead_nxt = shift_r[0];
                phase_nxt  = smoe_pkg::PH_CMD;
              end else begin
                oe_nxt    = 1'b0;
                state_nxt = smoe_pkg::ST_IDLE;
              end
            end else if (phase_r == smoe_pkg::PH_CMD) begin
              index_nxt = shift_r;
              phase_nxt = smoe_pkg::PH_CNT;
            end else if (phase_r == smoe_pkg::PH_CNT) begin
              phase_nxt = smoe_pkg::PH_DATA; // count only acknowledged; stop ends it
            end else begin
              if (index_r == smoe_pkg::IDX_FAST) begin
                regFast_nxt = shift_r;
              end else if (index_r == smoe_pkg::IDX_SEL) begin
                regSel_nxt = shift_r;
              end else if (index_r == smoe_pkg::IDX_SLOW) begin
                regSlow_nxt = shift_r & smoe_pkg::SLOW_WR_MASK;
              end
              index_nxt = index_r + 8'h01;
            end
          end
        end
        smoe_pkg::ST_RXACK: begin
          if (sclFall) begin
            bitCnt_nxt = '0;
            if (isRead_r && phase_r == smoe_pkg::PH_CMD) begin
              shift_nxt = smoe_pkg::READ_COUNT;
              oe_nxt    = ~smoe_pkg::READ_COUNT[7];
              state_nxt = smoe_pkg::ST_TX;
            end else begin
              oe_nxt    = 1'b0;
              state_nxt = smoe_pkg::ST_RX;
            end
          end
        end
        smoe_pkg::ST_TX: begin
          if (sclFall) begin
            bitCnt_nxt = bitCnt_r + 4'h1;
            if (bitCnt_r == smoe_pkg::LAST_BIT) begin
              oe_nxt    = 1'b0;
              state_nxt = smoe_pkg::ST_TXACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt    = ~shift_r[6];
            end
          end
        end
        smoe_pkg::ST_TXACK: begin
          if (sclRise) begin
            acked_nxt = ~lineS2_r.sda;
          end else if (sclFall) begin
            if (acked_r) begin
              shift_nxt = readReg(index_r, regFast_r, regSel_r, regSlow_r, latchedFreq_r);
              oe_nxt     = ~shift_nxt[7];
              index_nxt  = index_r + 8'h01;
              bitCnt_nxt = '0;
              state_nxt  = smoe_pkg::ST_TX;
            end else begin
              state_nxt = smoe_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
    groupFreq_nxt = regSlow_r[smoe_pkg::FREQ_SOURCE_BIT] ?
                    regSlow_r[smoe_pkg::FREQ_CHOICE_BIT] : pinS2_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= smoe_pkg::ST_IDLE;
      phase_r       <= smoe_pkg::PH_ADDR;
      bitCnt_r      <= '0;
      shift_r       <= '0;
      index_r       <= '0;
      isRead_r      <= 1'b0;
      oe_r          <= 1'b0;
      acked_r       <= 1'b0;
      regFast_r     <= smoe_pkg::FAST_RST;
      regSel_r      <= smoe_pkg::SEL_RST;
      regSlow_r     <= smoe_pkg::SLOW_RST;
      latchedFreq_r <= 1'b0;
      groupFreq_r   <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      phase_r       <= phase_nxt;
      bitCnt_r      <= bitCnt_nxt;
      shift_r       <= shift_nxt;
      index_r       <= index_nxt;
      isRead_r      <= isRead_nxt;
      oe_r          <= oe_nxt;
      acked_r       <= acked_nxt;
      regFast_r     <= regFast_nxt;
      regSel_r      <= regSel_nxt;
      regSlow_r     <= regSlow_nxt;
      latchedFreq_r <= latchedFreq_nxt;
      groupFreq_r   <= groupFreq_nxt;
    end
  end

  assign sdaOut                   = sdaLow_r;
  assign sdaOe                    = oe_r;
  assign fixedFastClockEnable     = regFast_r[smoe_pkg::FAST_EN_MSB:0];
  assign selectableClockEnable    = {regFast_r[smoe_pkg::SEL8_EN_BIT], regSel_r};
  assign fixedSlowClockEnable     = regSlow_r[smoe_pkg::SLOW_EN_MSB:0];
  assign platformTimeOutputEnable = regSlow_r[smoe_pkg::PFT_EN_BIT];
  assign selectableGroupFreq25    = groupFreq_r;
endmodule // smoe_top
`default_nettype wire
